/* File: hw/lsag_pkg.sv */
package lsag_pkg;

  // Register byte offsets on the bus.
  localparam logic [11:0] LSAG_OFS_MODE = 12'h000;
  localparam logic [11:0] LSAG_OFS_LAST = 12'h004;

  // Field positions inside the address mode register.
  localparam int LSAG_SEL_W = 2;
  localparam int LSAG_BLK0_LSB = 16;
  localparam int LSAG_BLK1_LSB = 21;
  localparam int LSAG_BLK_W = 5;
  localparam logic [31:0] LSAG_MODE_WMASK = 32'h03FF_FFFF;
  localparam logic [31:0] LSAG_MODE_RESET = 32'h0000_0000;

  // Register numbers that matter to address generation.
  localparam logic [4:0] LSAG_CIRC_FIRST = 5'h04;
  localparam logic [4:0] LSAG_CIRC_LAST = 5'h07;
  localparam logic [4:0] LSAG_LONG_BASE0 = 5'h0E;
  localparam logic [4:0] LSAG_LONG_BASE1 = 5'h0F;
  localparam int LSAG_BYTES = 8;

  // Two-bit mode selector per circular-capable register.
  typedef enum logic [1:0] {
    LSAG_LINEAR = 2'b00,
    LSAG_CIRC_FIRST_BLK = 2'b01,
    LSAG_CIRC_SECOND_BLK = 2'b10,
    LSAG_SEL_RSVD = 2'b11
  } lsag_sel_t;

  // Operation class of a request.
  typedef enum logic [1:0] {
    LSAG_OP_LDST = 2'b00,
    LSAG_OP_SCALED_ADD_ADDRESS = 2'b01,
    LSAG_OP_SCALED_SUB_ADDRESS = 2'b10,
    LSAG_OP_RSVD = 2'b11
  } lsag_op_t;

  // Access size: also the scaling shift.
  typedef enum logic [1:0] {
    LSAG_SZ_BYTE = 2'b00,
    LSAG_SZ_HALF = 2'b01,
    LSAG_SZ_WORD = 2'b10,
    LSAG_SZ_DWORD = 2'b11
  } lsag_size_t;

  // Request from instruction decode.
  typedef struct packed {
    lsag_op_t op;
    lsag_size_t size;
    logic [3:0] mode_field;
    logic unit_side;
    logic reg_side;
    logic [4:0] reg_num;
    logic nonaligned;
    logic nonscaled;
    logic long_cst;
    logic [31:0] base_register_operand;
    logic [31:0] offset_register_operand;
    logic [4:0] short_unsigned_offset;
    logic [14:0] long_unsigned_offset;
  } lsag_req_t;

  // Result toward memory access and writeback.
  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] access_addr;
    logic wb_en;
    logic reg_side;
    logic [4:0] reg_num;
    logic [31:0] wb_value;
  } lsag_res_t;

  // Whole state of the block.
  typedef struct packed {
    logic [31:0] address_mode_register;
    logic [31:0] prdata;
    logic pslverr;
    lsag_res_t res;
    logic [LSAG_BYTES*32-1:0] byte_addr;
  } lsag_state_t;

endpackage

/* File: hw/lsag_circ_wrap.sv */
`timescale 1ns/1ps

// Keeps the bits above N of the reference and takes bits N..0 of the new value.
module lsag_circ_wrap (
  // Operands.
  input wire logic [31:0] keep_val,
  input wire logic [31:0] new_val,
  input wire logic circ_en,
  input wire logic [4:0] blk_n,
  // Result.
  output logic [31:0] wrapped
);

  logic [31:0] low_mask;

  // A field of N gives a buffer of 2^(N+1) bytes, so N+1 low bits may move.
  always_comb
  begin
    low_mask = 32'hFFFF_FFFF >> (5'h1F - blk_n);
    if (circ_en)
    begin
      wrapped = (keep_val & ~low_mask) | (new_val & low_mask);
    end
    else
    begin
      wrapped = new_val;
    end
  end

endmodule // lsag_circ_wrap

/* File: hw/lsag_top.sv */
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps

// Operation
// - Linear, circular with first block size, circular with second block size.
// - Any register is linear; circular only for 4-7 on their own side's unit.
// - All load, store and scaled add/sub forms consult the mode register.
// - Load/store offsets shift by access size, then add or subtract.
// - Nonaligned doubleword accesses may take the offset unscaled.
// - Pre and offset forms access the result; post forms access the old base.
// - Scaled add/sub shift the offset operand by size, then add it to or subtract it from the base.
// - Circular mode changes only bits N..0; upper bits keep the base.
// - Two block-size fields give the two circular buffer sizes.
// - Buffer size counts bytes, never scaled by access size.
// - Nonaligned circular accesses wrap every adjacent byte address separately.
// - Long constant offset only with base 14/15, positive, no modification.
// - Otherwise offset is a register or a five-bit unsigned constant.
// - Codes 0000/0001/0100/0101 are negative/positive constant/register offsets.
// - Codes 1000-1011 pre/post modify by constant; 1100-1111 by register.
module lsag_top (
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request from decode.
  input wire logic req_valid,
  input wire lsag_pkg::lsag_req_t req,
  // Result toward memory and writeback.
  output lsag_pkg::lsag_res_t res,
  output logic [lsag_pkg::LSAG_BYTES*32-1:0] byte_addr
);

  localparam int LSAG_BYTES_L = lsag_pkg::LSAG_BYTES;

  lsag_pkg::lsag_state_t state_r;
  lsag_pkg::lsag_state_t state_nxt;

  logic [31:0] offset_raw;
  logic [31:0] offset_sh;
  logic [1:0] shift_amt;
  logic do_sub;
  logic [31:0] sum;
  logic [31:0] calc;
  logic circ_capable;
  logic circ_en;
  logic [1:0] sel;
  logic [4:0] blk_n;
  logic [2:0] sel_idx;
  logic is_post;
  logic modifies;
  logic req_err;
  logic [31:0] access_addr;
  logic [LSAG_BYTES_L*32-1:0] byte_addr_c;
  logic apb_setup;
  logic apb_wr_mode;

  // A register is circular-capable only in 4..7 and only through its own side's unit.
  assign circ_capable = (req.reg_num >= lsag_pkg::LSAG_CIRC_FIRST) &&
                        (req.reg_num <= lsag_pkg::LSAG_CIRC_LAST) &&
                        (req.reg_side == req.unit_side);
  assign sel_idx = {req.reg_side, req.reg_num[1:0]};
  assign sel = state_r.address_mode_register[sel_idx*lsag_pkg::LSAG_SEL_W +: 2];

  // The reserved selector code falls back to linear so it can never corrupt a base.
  always_comb
  begin
    circ_en = 1'b0;
    blk_n = 5'h00;
    case (sel)
      lsag_pkg::LSAG_LINEAR:
      begin
        circ_en = 1'b0;
      end
      lsag_pkg::LSAG_CIRC_FIRST_BLK:
      begin
        circ_en = circ_capable;
        blk_n = state_r.address_mode_register[lsag_pkg::LSAG_BLK0_LSB +: 5];
      end
      lsag_pkg::LSAG_CIRC_SECOND_BLK:
      begin
        circ_en = circ_capable;
        blk_n = state_r.address_mode_register[lsag_pkg::LSAG_BLK1_LSB +: 5];
      end
      default:
      begin
        circ_en = 1'b0;
      end
    endcase
  end

  // Offset selection, scaling and the add or subtract.
  always_comb
  begin
    if (req.long_cst)
    begin
      offset_raw = {17'h00000, req.long_unsigned_offset};
    end
    else if (req.op == lsag_pkg::LSAG_OP_LDST && !req.mode_field[2])
    begin
      offset_raw = {27'h0000000, req.short_unsigned_offset};
    end
    else
    begin
      offset_raw = req.offset_register_operand;
    end
    // Only the nonaligned doubleword forms may skip scaling.
    if (req.op == lsag_pkg::LSAG_OP_LDST && req.nonaligned && req.nonscaled &&
        req.size == lsag_pkg::LSAG_SZ_DWORD)
    begin
      shift_amt = 2'b00;
    end
    else
    begin
      shift_amt = req.size;
    end
    offset_sh = offset_raw << shift_amt;
    case (req.op)
      lsag_pkg::LSAG_OP_LDST:
      begin
        do_sub = !req.mode_field[0];
      end
      lsag_pkg::LSAG_OP_SCALED_SUB_ADDRESS:
      begin
        do_sub = 1'b1;
      end
      default:
      begin
        do_sub = 1'b0;
      end
    endcase
    sum = do_sub ? (req.base_register_operand - offset_sh) :
                   (req.base_register_operand + offset_sh);
  end

  // Circular bit preservation against the prior base; the size is counted in bytes.
  lsag_circ_wrap u_wrap_main (
    .keep_val(req.base_register_operand),
    .new_val(sum),
    .circ_en(circ_en),
    .blk_n(blk_n),
    .wrapped(calc)
  );

  // Form decode and legality.
  always_comb
  begin
    is_post = 1'b0;
    modifies = 1'b0;
    req_err = 1'b0;
    case (req.op)
      lsag_pkg::LSAG_OP_LDST:
      begin
        modifies = req.mode_field[3];
        is_post = req.mode_field[3] && req.mode_field[1];
        // Without modification only 0x00/0x01 patterns with bit 1 clear exist.
        if (!req.mode_field[3] && req.mode_field[1])
        begin
          req_err = 1'b1;
        end
        if (req.long_cst && (req.mode_field != 4'b0001 || !req.reg_side ||
            (req.reg_num != lsag_pkg::LSAG_LONG_BASE0 &&
             req.reg_num != lsag_pkg::LSAG_LONG_BASE1)))
        begin
          req_err = 1'b1;
        end
      end
      lsag_pkg::LSAG_OP_SCALED_ADD_ADDRESS:
      begin
        modifies = 1'b1;
        req_err = req.long_cst;
      end
      lsag_pkg::LSAG_OP_SCALED_SUB_ADDRESS:
      begin
        modifies = 1'b1;
        req_err = req.long_cst || (req.size == lsag_pkg::LSAG_SZ_DWORD);
      end
      default:
      begin
        req_err = 1'b1;
      end
    endcase
    access_addr = is_post ? req.base_register_operand : calc;
  end

  // Each logically adjacent byte is wrapped on its own, so data crosses the edge.
  genvar gi;
  generate
    for (gi = 0; gi < LSAG_BYTES_L; gi = gi + 1)
    begin : g_byte
      logic [31:0] adj;
      assign adj = access_addr + 32'(gi);
      lsag_circ_wrap u_wrap_byte (
        .keep_val(access_addr),
        .new_val(adj),
        .circ_en(circ_en),
        .blk_n(blk_n),
        .wrapped(byte_addr_c[gi*32 +: 32])
      );
    end
  endgenerate

  assign apb_setup = psel && !penable;
  assign apb_wr_mode = psel && penable && pwrite && (paddr == lsag_pkg::LSAG_OFS_MODE);

  // Next state: bus register file and the registered result.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.res.valid = 1'b0;
    // Read data is captured in the setup cycle so it leaves from a flip-flop.
    if (apb_setup)
    begin
      state_nxt.pslverr = 1'b0;
      state_nxt.prdata = 32'h0000_0000;
      if (paddr == lsag_pkg::LSAG_OFS_MODE)
      begin
        state_nxt.prdata = state_r.address_mode_register;
      end
      else if (paddr == lsag_pkg::LSAG_OFS_LAST)
      begin
        state_nxt.prdata = state_r.res.access_addr;
        state_nxt.pslverr = pwrite;
      end
      else
      begin
        state_nxt.pslverr = 1'b1;
      end
    end
    if (apb_wr_mode)
    begin
      state_nxt.address_mode_register = pwdata & lsag_pkg::LSAG_MODE_WMASK;
    end
    // The mode register is consulted for every request class.
    if (req_valid)
    begin
      state_nxt.res.valid = 1'b1;
      state_nxt.res.err = req_err;
      state_nxt.res.access_addr = access_addr;
      state_nxt.res.wb_en = modifies && !req_err;
      state_nxt.res.reg_side = req.reg_side;
      state_nxt.res.reg_num = req.reg_num;
      state_nxt.res.wb_value = calc;
      state_nxt.byte_addr = byte_addr_c;
    end
  end

  // All state freezes while the clock enable is low.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= '0;
      state_r.address_mode_register <= lsag_pkg::LSAG_MODE_RESET;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
    end
  end

  assign prdata = state_r.prdata;
  assign pslverr = state_r.pslverr && psel && penable;
  assign pready = 1'b1;
  assign res = state_r.res;
  assign byte_addr = state_r.byte_addr;

  // Checks.
  sequence s_apb_setup;
    psel && !penable;
  endsequence

  sequence s_apb_access;
    psel && penable;
  endsequence

  a_apb_answer_ready: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_setup ##1 s_apb_access |-> pready) else $error("APB access not answered.");

  a_mode_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr_mode && clk_en) |=> (state_r.address_mode_register ==
      ($past(pwdata) & lsag_pkg::LSAG_MODE_WMASK))) else $error("Mode write lost.");

  a_circ_only_capable: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && !circ_capable) |-> (calc == sum)) else $error("Wrap on other unit.");

  a_circ_upper_kept: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && circ_en) |-> (((calc ^ req.base_register_operand) >> blk_n) <= 32'h1))
    else $error("Upper address bits moved.");

  a_post_old_base: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && clk_en && is_post) |=> (res.access_addr == $past(req.base_register_operand)))
    else $error("Post form used new address.");

  a_scale_linear: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && !circ_en && req.op == lsag_pkg::LSAG_OP_LDST && !req.nonscaled &&
     !do_sub) |-> (sum == req.base_register_operand + (offset_raw << req.size)))
    else $error("Linear scaling wrong.");

  a_long_cst_legal: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && clk_en && req.long_cst && req.mode_field[3]) |=> (res.valid && res.err && !res.wb_en))
    else $error("Modified long constant form accepted.");

  a_no_dword_scaled_sub_address: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && clk_en && req.op == lsag_pkg::LSAG_OP_SCALED_SUB_ADDRESS &&
     req.size == lsag_pkg::LSAG_SZ_DWORD) |=> res.err) else $error("Dword sub accepted.");

  a_writeback_modify: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && clk_en && req.op == lsag_pkg::LSAG_OP_LDST && !req_err) |=>
      (res.wb_en == $past(req.mode_field[3]))) else $error("Writeback enable wrong.");

  a_byte_first_equal: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && clk_en) ##1 res.valid |-> (byte_addr[31:0] == res.access_addr))
    else $error("First byte address differs.");

  // Scaled add: the register operand is shifted by size and then added.
  a_scaled_add_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && req.op == lsag_pkg::LSAG_OP_SCALED_ADD_ADDRESS && !circ_en) |->
      (sum == req.base_register_operand + (req.offset_register_operand << req.size)))
    else $error("Scaled add wrong.");

  // Scaled subtract: the same shift, then a subtraction.
  a_scaled_sub_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && req.op == lsag_pkg::LSAG_OP_SCALED_SUB_ADDRESS && !circ_en) |->
      (sum == req.base_register_operand - (req.offset_register_operand << req.size)))
    else $error("Scaled subtract wrong.");

  // Short constant forms must take the five-bit field, never the register operand.
  a_short_offset_pick: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && req.op == lsag_pkg::LSAG_OP_LDST && !req.long_cst && !req.mode_field[2]) |->
      (offset_raw == {27'h0000000, req.short_unsigned_offset}))
    else $error("Offset source wrong.");

  // The last byte of a circular access must still sit inside the same buffer.
  a_byte_last_inside: assert property (@(posedge pclk) disable iff (!presetn)
    (req_valid && clk_en && circ_en) |=>
      (((byte_addr[LSAG_BYTES_L*32-1 -: 32] ^ res.access_addr) >> $past(blk_n)) <= 32'h1))
    else $error("Byte address left the buffer.");

  // A low enable holds every register, so a stalled pipeline loses nothing.
  a_enable_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(state_r)) else $error("State moved while frozen.");

endmodule // lsag_top

/* File: test/lsag_decode_model.sv */
`timescale 1ns/1ps

// Decode stage stand-in: issues one request and takes the result a cycle later.
module lsag_decode_model (
  // Clock.
  input wire logic pclk,
  // Request toward the block.
  output logic req_valid,
  output lsag_pkg::lsag_req_t req,
  // Result from the block.
  input wire lsag_pkg::lsag_res_t res,
  input wire logic [lsag_pkg::LSAG_BYTES*32-1:0] byte_addr
);
  lsag_pkg::lsag_res_t got;
  logic [lsag_pkg::LSAG_BYTES*32-1:0] got_b;

  // Lines start quiet so the first edge after reset sees no request.
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end

  // A released request is inverted so stale operands can never pass as live ones.
  task automatic xfer(input lsag_pkg::lsag_req_t r);
    @(posedge pclk);
    req_valid <= 1'b1;
    req <= r;
    @(posedge pclk);
    req_valid <= 1'b0;
    req <= ~r;
    #1;
    got = res;
    got_b = byte_addr;
  endtask
endmodule // lsag_decode_model

/* File: test/tb_load_store_address_generator.sv */
`timescale 1ns/1ps

module tb_load_store_address_generator;
  logic pclk;
  logic presetn;
  logic clk_en;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic req_valid;
  lsag_pkg::lsag_req_t req;
  lsag_pkg::lsag_res_t res;
  logic [lsag_pkg::LSAG_BYTES*32-1:0] byte_addr;
  int n_mismatch;
  int checks;
  int cycles;
  logic [31:0] rd;
  logic er;

  lsag_top lsag_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req), .res(res),
    .byte_addr(byte_addr));

  lsag_decode_model lsag_decode_model_i (.pclk(pclk), .req_valid(req_valid), .req(req),
    .res(res), .byte_addr(byte_addr));

  // Free-running bus clock.
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // A hang ends the run well past the few hundred cycles the tests need.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic lsag_pkg::lsag_req_t rq(input logic [1:0] op, input logic [1:0] sz,
      input logic [3:0] m, input logic us, input logic rs, input logic [4:0] rn,
      input logic [31:0] b, input logic [31:0] o);
    lsag_pkg::lsag_req_t r;
    r = '0;
    r.op = lsag_pkg::lsag_op_t'(op);
    r.size = lsag_pkg::lsag_size_t'(sz);
    r.mode_field = m;
    r.unit_side = us;
    r.reg_side = rs;
    r.reg_num = rn;
    r.base_register_operand = b;
    r.offset_register_operand = o;
    r.short_unsigned_offset = o[4:0];
    return r;
  endfunction

  // Sends one request and judges the result; a refused one skips the address check.
  task automatic go(input lsag_pkg::lsag_req_t r, input logic [31:0] acc,
      input logic [31:0] wv, input logic we, input logic e);
    lsag_decode_model_i.xfer(r);
    chk(lsag_decode_model_i.got.valid, 32'h1, "valid");
    chk(lsag_decode_model_i.got.err, e, "err");
    chk(lsag_decode_model_i.got.wb_en, we, "wb_en");
    chk({lsag_decode_model_i.got.reg_side, lsag_decode_model_i.got.reg_num},
      {r.reg_side, r.reg_num}, "wb reg");
    if (!e)
      chk(lsag_decode_model_i.got.access_addr, acc, "addr");
    if (we)
      chk(lsag_decode_model_i.got.wb_value, wv, "wb_value");
  endtask

  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0, "mode reset");
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h03FF_FFFF, "mode rw");
    apb(1'b1, 12'h004, 32'h1);
    chk(er, 32'h1, "ro write");
    apb(1'b0, 12'h008, 32'h0);
    chk(er, 32'h1, "unmapped");
    apb(1'b1, 12'h000, 32'h0);
  endtask

  task automatic t_linear;
    logic [31:0] s;
    logic [31:0] a;
    for (int z = 0; z < 4; z++)
    begin
      for (int c = 0; c < 16; c++)
      begin
        s = c[0] ? 32'h1000 + (32'h3 << z) : 32'h1000 - (32'h3 << z);
        a = (c[3] & c[1]) ? 32'h1000 : s;
        go(rq(2'h0, z[1:0], c[3:0], 1'b0, 1'b0, 5'h04, 32'h1000, 32'h3), a, s, c[3],
          !c[3] & c[1]);
      end
      s = 32'h1000 + (32'h3 << z);
      go(rq(2'h1, z[1:0], 4'h0, 1'b0, 1'b0, 5'h04, 32'h1000, 32'h3), s, s, 1'b1, 1'b0);
      s = 32'h1000 - (32'h3 << z);
      go(rq(2'h2, z[1:0], 4'h0, 1'b0, 1'b0, 5'h04, 32'h1000, 32'h3), s, s, z < 3, z == 3);
    end
  endtask

  task automatic t_circ;
    // The first buffer is 32 bytes; the later 16-byte one only serves an aligned add.
    apb(1'b1, 12'h000, 32'h0004_0001);
    go(rq(2'h0, 2'h2, 4'h9, 1'b0, 1'b0, 5'h04, 32'h100, 32'h9), 32'h104, 32'h104, 1'b1, 1'b0);
    go(rq(2'h1, 2'h1, 4'h0, 1'b0, 1'b0, 5'h04, 32'h100, 32'h13), 32'h106, 32'h106, 1'b1, 1'b0);
    go(rq(2'h0, 2'h2, 4'hB, 1'b0, 1'b0, 5'h04, 32'h11C, 32'h1), 32'h11C, 32'h100, 1'b1, 1'b0);
    go(rq(2'h0, 2'h2, 4'h9, 1'b1, 1'b0, 5'h04, 32'h100, 32'h9), 32'h124, 32'h124, 1'b1, 1'b0);
    go(rq(2'h0, 2'h2, 4'h9, 1'b0, 1'b0, 5'h05, 32'h100, 32'h9), 32'h124, 32'h124, 1'b1, 1'b0);
    apb(1'b1, 12'h000, 32'h0064_0800);
    go(rq(2'h1, 2'h0, 4'h0, 1'b1, 1'b1, 5'h05, 32'h23C, 32'h8), 32'h234, 32'h234, 1'b1, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h234, "last addr");
    chk(er, 32'h0, "last addr err");
  endtask

  task automatic t_unal;
    lsag_pkg::lsag_req_t r;
    apb(1'b1, 12'h000, 32'h0004_0001);
    r = rq(2'h0, 2'h2, 4'h9, 1'b0, 1'b0, 5'h04, 32'h3A, 32'h2);
    r.nonaligned = 1'b1;
    go(r, 32'h22, 32'h22, 1'b1, 1'b0);
    r = rq(2'h0, 2'h2, 4'h1, 1'b0, 1'b0, 5'h04, 32'h3E, 32'h0);
    r.nonaligned = 1'b1;
    go(r, 32'h3E, 32'h0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
      chk(lsag_decode_model_i.got_b[32*i+:32], 32'h20 | ((32'h3E + i) & 32'h1F), "byte");
    apb(1'b1, 12'h000, 32'h0);
    r = rq(2'h0, 2'h3, 4'h1, 1'b0, 1'b0, 5'h00, 32'h1000, 32'h5);
    r.nonaligned = 1'b1;
    r.nonscaled = 1'b1;
    go(r, 32'h1005, 32'h0, 1'b0, 1'b0);
    r.nonscaled = 1'b0;
    go(r, 32'h1028, 32'h0, 1'b0, 1'b0);
    r = rq(2'h0, 2'h0, 4'h1, 1'b1, 1'b1, 5'h0E, 32'h8000, 32'h0);
    r.long_cst = 1'b1;
    r.long_unsigned_offset = 15'h7FFF;
    go(r, 32'hFFFF, 32'h0, 1'b0, 1'b0);
    r.reg_side = 1'b0;
    go(r, 32'h0, 32'h0, 1'b0, 1'b1);
    r.reg_side = 1'b1;
    r.mode_field = 4'h9;
    go(r, 32'h0, 32'h0, 1'b0, 1'b1);
  endtask

  // A low enable must ignore requests and bus writes; the last result stands meanwhile.
  task automatic t_hold;
    @(posedge pclk);
    clk_en <= 1'b0;
    lsag_decode_model_i.xfer(rq(2'h1, 2'h0, 4'h0, 1'b0, 1'b0, 5'h04, 32'h10, 32'h1));
    chk(lsag_decode_model_i.got.valid, 32'h0, "frozen valid");
    chk(lsag_decode_model_i.got.access_addr, 32'hFFFF, "frozen addr");
    apb(1'b1, 12'h000, 32'h0000_0005);
    clk_en <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0, "frozen mode");
  endtask

  // Reset for 16 cycles, then each scenario in turn.
  initial
  begin
    n_mismatch = 0;
    checks = 0;
    cycles = 0;
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk(res.valid, 32'h0, "res reset");
    t_regs();
    t_linear();
    t_circ();
    t_unal();
    t_hold();
    print_verdict();
  end
endmodule // tb_load_store_address_generator
